/* File: rtl/acp_reg_port.sv */
// Serial two-wire register port of the three-axis sample block.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Acknowledge our address byte with write direction after a start.
// - Acknowledge the next byte and latch it as the register pointer.
// - After a repeated start with read direction, use the latched pointer.
// - After the read address ack, drive the addressed register's byte.
// - Bytes start at clock falls, eight bits, most significant bit first.
// - Advance the pointer after each byte returned in a read.
// - Keep sending while the master acks; a no-ack and stop end the burst.
// - Write: address, register byte, data byte, each acked, then a stop.
// - A completed acked write is dropped; no register the pointer selects takes it.
// - Acknowledge each further write byte and advance the pointer after it.
// - High register holds sample bits 11-4; low register bits 7-4 hold 3-0.
// - Answer only when all seven address bits match the fixed address.
// - Ninth clock is the ack slot; receiver holds data low through its high.
module acp_reg_port import acp_pkg::*; #(
	parameter int FIFO_DEPTH = ACP_FIFO_DEPTH
) (
	input wire logic mclk, // Main clock, 125 MHz.
	input wire logic resetn, // Asynchronous reset, active low.
	input wire logic sample_clk, // Clock of the sample source.
	input wire logic sample_valid, // Sample source offers a sample set.
	input wire acp_sample_t sample_data, // Offered sample set.
	output logic sample_ready, // Sample set taken on this edge.
	input wire logic scl_i, // Serial clock pin level.
	input wire logic sda_i, // Serial data pin level.
	output logic sda_o, // Serial data drive value, always low.
	output logic sda_oe // Serial data pulled low while high.
);
	localparam int SW = $bits(acp_sample_t);

	if (FIFO_DEPTH < 2) begin : g_bad_depth
		$error("acp_reg_port needs a buffer of at least two sets");
	end

	// State of the sample clock side.
	typedef struct packed {
		logic req_tog;
		acp_sample_t word;
	} acp_src_st_t;

	// State of the main clock side.
	typedef struct packed {
		acp_phase_t phase;
		logic [3:0] bitcnt;
		logic [7:0] shreg;
		logic [7:0] tx;
		logic [7:0] ptr;
		logic rw;
		logic matched;
		logic mack;
		logic drive_low;
		logic ack_tog;
		logic ready;
		acp_sample_t out;
		logic scl_d;
		logic sda_d;
	} acp_port_st_t;

	acp_src_st_t src;
	acp_src_st_t next_src;
	acp_port_st_t st;
	acp_port_st_t next_st;
	logic [1:0] pins_s;
	logic scl_s;
	logic sda_s;
	logic req_s;
	logic ack_s;
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;
	logic ack_slot;
	logic fifo_in_valid;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic [SW-1:0] fifo_out_data;
	logic [7:0] rd_byte;

	////////////////////////////////////////////////////////////////////////
	// Register decode and pointer stepping.

	// Next pointer: the last axis byte wraps back to status.
	function automatic logic [7:0] step_ptr(input logic [7:0] p);
		if (p == ACP_REG_Z_LOW) begin
			return ACP_REG_STATUS;
		end
		return p + 8'h01;
	endfunction

	// Read value of one offset.
	function automatic logic [7:0] read_reg(input logic [7:0] p,
			input acp_sample_t s, input logic rdy, input logic full);
		logic [7:0] v;
		v = 8'h00;
		case (p)
			ACP_REG_STATUS: begin
				v = ACP_STATUS_RESET;
				v[ACP_STATUS_READY_BIT] = rdy;
				v[ACP_STATUS_FULL_BIT] = full;
			end
			ACP_REG_X_HIGH: v = s.x[11:4];
			ACP_REG_X_LOW: v = {s.x[3:0], ACP_LOW_PAD};
			ACP_REG_Y_HIGH: v = s.y[11:4];
			ACP_REG_Y_LOW: v = {s.y[3:0], ACP_LOW_PAD};
			ACP_REG_Z_HIGH: v = s.z[11:4];
			ACP_REG_Z_LOW: v = {s.z[3:0], ACP_LOW_PAD};
			default: v = 8'h00;
		endcase
		return v;
	endfunction

	// No location in this map takes a write.
	function automatic logic writable(input logic [7:0] p);
		return (p > ACP_REG_GAP_B) && 1'b0;
	endfunction

	assign rd_byte = read_reg(st.ptr, st.out, st.ready, ~fifo_in_ready);

	////////////////////////////////////////////////////////////////////////
	// Sample clock side: hold a set and toggle a request.

	acp_sync #(.W(1)) u_ack_sync (
		.clk(sample_clk),
		.resetn(resetn),
		.d(st.ack_tog),
		.q(ack_s)
	);

	// Idle when the request has been answered; stalls while buffer is full.
	assign sample_ready = src.req_tog == ack_s;

	// Capture a new set only while no request is outstanding.
	always_comb begin
		next_src = src;
		if (sample_valid && sample_ready) begin
			next_src.word = sample_data;
			next_src.req_tog = ~src.req_tog;
		end
	end

	// Sample side register.
	always_ff @(posedge sample_clk or negedge resetn) begin
		if (!resetn) begin
			src <= '0;
		end else begin
			src <= next_src;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Main clock side: crossing, buffer and output registers.

	acp_sync #(.W(2)) u_pin_sync (
		.clk(mclk),
		.resetn(resetn),
		.d({scl_i, sda_i}),
		.q(pins_s)
	);

	acp_sync #(.W(1)) u_req_sync (
		.clk(mclk),
		.resetn(resetn),
		.d(src.req_tog),
		.q(req_s)
	);

	// The held set is stable while its request is unanswered.
	assign fifo_in_valid = req_s != st.ack_tog;
	// Refresh the axis bytes only between transfers, once the last is read.
	assign fifo_out_ready = (st.phase == PH_IDLE) && !st.ready;

	acp_fifo #(.W(SW), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(mclk),
		.resetn(resetn),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data(src.word),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);

	assign scl_s = pins_s[1];
	assign sda_s = pins_s[0];
	assign scl_rise = scl_s & ~st.scl_d;
	assign scl_fall = ~scl_s & st.scl_d;
	// A start while busy is a repeated start; start_cond serves both alike.
	assign start_cond = scl_s & st.scl_d & st.sda_d & ~sda_s;
	assign stop_cond = scl_s & st.scl_d & ~st.sda_d & sda_s;
	assign ack_slot = st.bitcnt == ACP_ACK_SLOT;

	////////////////////////////////////////////////////////////////////////
	// Serial engine.
	always_comb begin
		next_st = st;
		next_st.scl_d = scl_s;
		next_st.sda_d = sda_s;
		// Answer the crossing handshake once the buffer takes the set.
		if (fifo_in_valid && fifo_in_ready) begin
			next_st.ack_tog = ~st.ack_tog;
		end
		if (start_cond) begin
			next_st.phase = PH_ADDR;
			// The fall that follows a start carries no bit; it wraps to 0.
			next_st.bitcnt = ACP_START_BIT;
			next_st.drive_low = 1'b0;
		end else if (stop_cond) begin
			next_st.phase = PH_IDLE;
			next_st.bitcnt = ACP_FIRST_BIT;
			next_st.drive_low = 1'b0;
		end else if (st.phase != PH_IDLE && scl_rise) begin
			// Bits are sampled while the clock is high.
			if (!ack_slot && st.phase != PH_RDATA) begin
				next_st.shreg = {st.shreg[6:0], sda_s};
			end else if (ack_slot && st.phase == PH_RDATA) begin
				next_st.mack = ~sda_s;
			end
		end else if (st.phase != PH_IDLE && scl_fall) begin
			if (st.bitcnt == ACP_LAST_BIT) begin
				// Eighth bit done: open the ack slot.
				next_st.bitcnt = ACP_ACK_SLOT;
				next_st.drive_low = 1'b0;
				case (st.phase)
					PH_ADDR: begin
						next_st.matched = st.shreg[7:1] == ACP_SLAVE_ADDR;
						next_st.rw = st.shreg[0];
						next_st.drive_low = st.shreg[7:1] == ACP_SLAVE_ADDR;
					end
					PH_REG: begin
						next_st.ptr = st.shreg;
						next_st.drive_low = 1'b1;
					end
					PH_WDATA: begin
						// Read-only map: the byte is taken and dropped.
						if (writable(st.ptr)) begin
							next_st.shreg = st.shreg;
						end
						next_st.ptr = step_ptr(st.ptr);
						next_st.drive_low = 1'b1;
					end
					default: next_st.drive_low = 1'b0;
				endcase
			end else if (ack_slot) begin
				// Ack slot over: pick the next byte's role.
				next_st.bitcnt = ACP_FIRST_BIT;
				next_st.drive_low = 1'b0;
				case (st.phase)
					PH_ADDR: begin
						if (!st.matched) begin
							next_st.phase = PH_IDLE;
						end else if (st.rw) begin
							next_st.phase = PH_RDATA;
						end else begin
							next_st.phase = PH_REG;
						end
					end
					PH_REG: next_st.phase = PH_WDATA;
					PH_WDATA: next_st.phase = PH_WDATA;
					default: begin
						if (st.phase == PH_RDATA && !st.mack) begin
							next_st.phase = PH_IDLE;
						end
					end
				endcase
				// Load and present the first bit of a returned byte.
				if ((st.phase == PH_ADDR && st.matched && st.rw) ||
						(st.phase == PH_RDATA && st.mack)) begin
					next_st.phase = PH_RDATA;
					next_st.tx = rd_byte;
					next_st.drive_low = ~rd_byte[7];
					next_st.ptr = step_ptr(st.ptr);
					if (st.ptr == ACP_REG_Z_LOW) begin
						next_st.ready = 1'b0;
					end
				end
			end else begin
				next_st.bitcnt = st.bitcnt + 4'h1;
				if (st.phase == PH_RDATA) begin
					next_st.drive_low = ~st.tx[3'h6 - st.bitcnt[2:0]];
				end
			end
		end
		// A new set wins over the clear of the ready flag.
		if (fifo_out_valid && fifo_out_ready) begin
			next_st.out = acp_sample_t'(fifo_out_data);
			next_st.ready = 1'b1;
		end
	end

	// Main side register; the pins idle high.
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			st <= '0;
			st.phase <= PH_IDLE;
			st.ptr <= ACP_PTR_RESET;
			st.scl_d <= 1'b1;
			st.sda_d <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign sda_o = 1'b0;
	assign sda_oe = st.drive_low;

	////////////////////////////////////////////////////////////////////////
	// Checks.

	a_addr_match: assert property (@(posedge mclk) disable iff (!resetn)
		st.phase == PH_ADDR && scl_fall && !start_cond && !stop_cond &&
		st.bitcnt == ACP_LAST_BIT && st.shreg[7:1] == ACP_SLAVE_ADDR
		|=> sda_oe && ack_slot)
		else $error("address byte not acknowledged");

	a_addr_foreign: assert property (@(posedge mclk) disable iff (!resetn)
		st.phase == PH_ADDR && scl_fall && !start_cond && !stop_cond &&
		st.bitcnt == ACP_LAST_BIT && st.shreg[7:1] != ACP_SLAVE_ADDR
		|=> !sda_oe ##1 (!sda_oe && st.phase == PH_ADDR) [*1])
		else $error("foreign address acknowledged");

	a_ptr_latch: assert property (@(posedge mclk) disable iff (!resetn)
		st.phase == PH_REG && scl_fall && !start_cond && !stop_cond &&
		st.bitcnt == ACP_LAST_BIT |=> st.ptr == $past(st.shreg) && sda_oe)
		else $error("register pointer not latched");

	a_read_load: assert property (@(posedge mclk) disable iff (!resetn)
		$rose(st.phase == PH_RDATA) |-> st.tx == $past(rd_byte) &&
		sda_oe == ~st.tx[7])
		else $error("returned byte is not the addressed register");

	a_ptr_step: assert property (@(posedge mclk) disable iff (!resetn)
		$changed(st.tx) && st.phase == PH_RDATA |->
		st.ptr == step_ptr($past(st.ptr)))
		else $error("pointer did not advance after a returned byte");

	a_nak_ends: assert property (@(posedge mclk) disable iff (!resetn)
		st.phase == PH_RDATA && ack_slot && scl_fall && !st.mack &&
		!start_cond && !stop_cond |=> st.phase == PH_IDLE ##1 !sda_oe)
		else $error("burst read continued after no-acknowledge");

	a_ack_held: assert property (@(posedge mclk) disable iff (!resetn)
		sda_oe && ack_slot && scl_rise |=> sda_oe throughout scl_s [*2])
		else $error("ack released while clock high");

	a_ro_kept: assert property (@(posedge mclk) disable iff (!resetn)
		st.phase == PH_WDATA && scl_fall && st.bitcnt == ACP_LAST_BIT &&
		!start_cond && !stop_cond && !(fifo_out_valid && fifo_out_ready)
		|=> $stable(st.out) && sda_oe)
		else $error("write changed a read-only register");

	a_gap_zero: assert property (@(posedge mclk) disable iff (!resetn)
		st.ptr > ACP_REG_Z_LOW |-> rd_byte == 8'h00)
		else $error("reserved location read non-zero");

	a_low_nibble: assert property (@(posedge mclk) disable iff (!resetn)
		st.ptr == ACP_REG_Y_LOW |-> rd_byte == {st.out.y[3:0], ACP_LOW_PAD})
		else $error("low sample byte misaligned");
endmodule
`default_nettype wire

/* File: rtl/acp_pkg.sv */
// Shared constants and types of the accelerometer register port.
package acp_pkg;

	////////////////////////////////////////////////////////////////////////
	// Link addressing and byte framing.
	localparam logic [6:0] ACP_SLAVE_ADDR = 7'h1d;
	localparam logic [3:0] ACP_LAST_BIT = 4'h7;
	localparam logic [3:0] ACP_ACK_SLOT = 4'h8;
	localparam logic [3:0] ACP_FIRST_BIT = 4'h0;
	// Count loaded by a start; the clock fall after the start wraps it to 0.
	localparam logic [3:0] ACP_START_BIT = 4'hf;

	////////////////////////////////////////////////////////////////////////
	// Register offsets.
	localparam logic [7:0] ACP_REG_STATUS = 8'h00;
	localparam logic [7:0] ACP_REG_X_HIGH = 8'h01;
	localparam logic [7:0] ACP_REG_X_LOW = 8'h02;
	localparam logic [7:0] ACP_REG_Y_HIGH = 8'h03;
	localparam logic [7:0] ACP_REG_Y_LOW = 8'h04;
	localparam logic [7:0] ACP_REG_Z_HIGH = 8'h05;
	localparam logic [7:0] ACP_REG_Z_LOW = 8'h06;
	localparam logic [7:0] ACP_REG_GAP_A = 8'h07;
	localparam logic [7:0] ACP_REG_GAP_B = 8'h08;
	localparam logic [7:0] ACP_PTR_RESET = 8'h00;

	////////////////////////////////////////////////////////////////////////
	// Status layout and reset values.
	localparam logic [7:0] ACP_STATUS_RESET = 8'h00;
	localparam int ACP_STATUS_READY_BIT = 3;
	localparam int ACP_STATUS_FULL_BIT = 7;
	localparam logic [3:0] ACP_LOW_PAD = 4'h0;

	////////////////////////////////////////////////////////////////////////
	// Sample path sizes.
	localparam int ACP_SAMPLE_W = 12;
	localparam int ACP_FIFO_DEPTH = 8;

	// One set of axis samples.
	typedef struct packed {
		logic [ACP_SAMPLE_W-1:0] x;
		logic [ACP_SAMPLE_W-1:0] y;
		logic [ACP_SAMPLE_W-1:0] z;
	} acp_sample_t;

	// Transfer phase of the serial engine.
	typedef enum logic [2:0] {
		PH_IDLE,
		PH_ADDR,
		PH_REG,
		PH_WDATA,
		PH_RDATA
	} acp_phase_t;

endpackage

/* File: rtl/acp_sync.sv */
// Two-flop level synchroniser for a group of bits.
`timescale 1ns/10ps
`default_nettype none
module acp_sync #(
	parameter int W = 1
) (
	input wire logic clk, // Destination clock.
	input wire logic resetn, // Asynchronous reset, active low.
	input wire logic [W-1:0] d, // Level from another domain.
	output logic [W-1:0] q // Synchronised level.
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] q;
	} acp_sync_st_t;

	acp_sync_st_t st;
	acp_sync_st_t next_st;

	// The first stage feeds only the second stage.
	always_comb begin
		next_st.meta = d;
		next_st.q = st.meta;
	end

	// Both stages reset low.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign q = st.q;
endmodule
`default_nettype wire

/* File: rtl/acp_fifo.sv */
// Sample buffer with valid and ready on both sides.
`timescale 1ns/10ps
`default_nettype none
module acp_fifo #(
	parameter int W = 36,
	parameter int DEPTH = 8
) (
	input wire logic clk, // Clock.
	input wire logic resetn, // Asynchronous reset, active low.
	input wire logic in_valid, // Word offered.
	output logic in_ready, // Room for a word.
	input wire logic [W-1:0] in_data, // Offered word.
	output logic out_valid, // Word available.
	input wire logic out_ready, // Consumer takes the word.
	output logic [W-1:0] out_data // Oldest word.
);
	localparam int AW = $clog2(DEPTH);

	// Depth must be a power of two so that pointers wrap by themselves.
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
		$error("acp_fifo depth must be a power of two of at least 2");
	end

	typedef struct packed {
		logic [AW:0] wr;
		logic [AW:0] rd;
	} acp_fifo_st_t;

	acp_fifo_st_t st;
	acp_fifo_st_t next_st;
	logic [W-1:0] mem [DEPTH];
	logic push;
	logic pop;

	// Full when the pointers differ only in the wrap bit.
	assign in_ready = (st.wr ^ st.rd) != {1'b1, {AW{1'b0}}};
	assign out_valid = st.wr != st.rd;
	assign out_data = mem[st.rd[AW-1:0]];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// Pointer advance.
	always_comb begin
		next_st = st;
		if (push) begin
			next_st.wr = st.wr + 1'b1;
		end
		if (pop) begin
			next_st.rd = st.rd + 1'b1;
		end
	end

	// Pointers reset to empty.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// Storage needs no reset.
	always_ff @(posedge clk) begin
		if (push) begin
			mem[st.wr[AW-1:0]] <= in_data;
		end
	end
endmodule
`default_nettype wire

/* File: dv/acp_i2c_master.sv */
// Bus master model that drives the two-wire link of the register port.
`timescale 1ns/10ps
`default_nettype none
module acp_i2c_master #(
	parameter int HALF_NS = 100
) (
	input wire logic sda_dev_oe, // Device pulls the data line low.
	output logic scl, // Serial clock level, high while idle.
	output wire logic sda // Resolved data line level.
);
	logic pull_low = 1'b0;

	initial begin
		scl = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// The line has a pull-up, so it reads high unless a party pulls it.
	assign sda = ~(pull_low | sda_dev_oe);

	////////////////////////////////////////////////////////////////////////
	// Start or repeated start: data falls while the clock is high.
	task automatic m_start();
		#(HALF_NS) pull_low = 1'b0;
		#(HALF_NS) scl = 1'b1;
		#(HALF_NS) pull_low = 1'b1;
		#(HALF_NS) scl = 1'b0;
	endtask

	// Stop: data rises while the clock is high, then the clock stands high.
	task automatic m_stop();
		#(HALF_NS / 2) pull_low = 1'b1;
		#(HALF_NS / 2) scl = 1'b1;
		#(HALF_NS) pull_low = 1'b0;
		#(HALF_NS);
	endtask

	// One clock: data changes in the low phase, is sampled mid high phase.
	task automatic bit_io(input logic b, output logic r);
		#(HALF_NS / 2) pull_low = ~b;
		#(HALF_NS / 2) scl = 1'b1;
		#(HALF_NS / 2) r = sda;
		#(HALF_NS / 2) scl = 1'b0;
	endtask

	// Eight bits most significant first, then the ninth acknowledge clock.
	task automatic xfer(input logic [7:0] wr, input logic ack_in,
			output logic [7:0] rd, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			bit_io(wr[i], rd[i]);
		end
		bit_io(ack_in, ack);
	endtask
endmodule
`default_nettype wire

/* File: dv/acp_reg_port_tb.sv */
// Self-checking bench of the accelerometer register port.
`timescale 1ns/10ps
`default_nettype none
module acp_reg_port_tb import acp_pkg::*; ();
	logic mclk = 1'b0;
	logic resetn = 1'b0;
	logic sample_clk = 1'b0;
	logic sample_valid = 1'b0;
	acp_sample_t sample_data = '0;
	logic sample_ready;
	logic sda_oe;
	wire logic sda_o;
	wire logic scl;
	wire logic sda;
	int n_errors = 0;
	int n_tests = 0;
	acp_sample_t sq[$];
	acp_sample_t last;
	logic [7:0] rb [0:9];

	acp_reg_port acp_reg_port_i (.mclk(mclk), .resetn(resetn),
		.sample_clk(sample_clk), .sample_valid(sample_valid),
		.sample_data(sample_data), .sample_ready(sample_ready),
		.scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe));
	acp_i2c_master acp_i2c_master_i (.sda_dev_oe(sda_oe), .scl(scl),
		.sda(sda));

	////////////////////////////////////////////////////////////////////////
	// Clocks: the sample clock is slower and unrelated in phase.
	initial begin
		forever #4 mclk = ~mclk;
	end
	initial begin
		#13;
		forever #40 sample_clk = ~sample_clk;
	end

	// Sample source offers queued sets and holds each until it is taken.
	always @(posedge sample_clk) begin
		if (!sample_valid || sample_ready) begin
			if (sq.size() > 0) begin
				sample_data <= sq.pop_front();
				sample_valid <= 1'b1;
			end else begin
				sample_valid <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Shared helpers.
	task automatic check(input string what, input logic [7:0] seen,
			input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	function automatic acp_sample_t mkset(input logic [3:0] k);
		return '{x: {k, 8'hb7}, y: {8'h5a, k}, z: {~k, 8'h3c}};
	endfunction

	task automatic put(input logic [7:0] b, input logic exp_ack,
			input string what);
		logic [7:0] rd;
		logic ack;
		acp_i2c_master_i.xfer(b, 1'b1, rd, ack);
		check(what, {7'h00, ack}, {7'h00, exp_ack});
	endtask

	task automatic point(input logic [7:0] r);
		acp_i2c_master_i.m_start();
		put(8'h3a, 1'b0, "write address ack");
		put(r, 1'b0, "register byte ack");
	endtask

	// Read n bytes from the pointer, acknowledging all but the last.
	task automatic fetch(input int n);
		logic ack;
		acp_i2c_master_i.m_start();
		put(8'h3b, 1'b0, "read address ack");
		for (int i = 0; i < n; i++) begin
			acp_i2c_master_i.xfer(8'hff, i == n - 1, rb[i], ack);
		end
		acp_i2c_master_i.m_stop();
	endtask

	task automatic check_set(input acp_sample_t s);
		check("x high", rb[1], s.x[11:4]);
		check("x low", rb[2], {s.x[3:0], 4'h0});
		check("y high", rb[3], s.y[11:4]);
		check("y low", rb[4], {s.y[3:0], 4'h0});
		check("z high", rb[5], s.z[11:4]);
		check("z low", rb[6], {s.z[3:0], 4'h0});
	endtask

	////////////////////////////////////////////////////////////////////////
	// Scenarios.
	task automatic t_idle();
		point(8'h00);
		fetch(1);
		check("status after reset", rb[0], 8'h00);
		acp_i2c_master_i.m_start();
		put(8'h3c, 1'b1, "foreign address nak");
		acp_i2c_master_i.m_stop();
		check("line released", {7'h00, sda_oe}, 8'h00);
		check("drive value", {7'h00, sda_o}, 8'h00);
	endtask

	task automatic t_burst();
		last = mkset(4'h1);
		sq.push_back(last);
		repeat (40) @(posedge sample_clk);
		point(8'h00);
		fetch(8);
		check("status ready", rb[0], 8'h08);
		check_set(last);
		check("wrapped status", rb[7], 8'h00);
	endtask

	task automatic t_reserved();
		point(8'h07);
		fetch(3);
		for (int i = 0; i < 3; i++) begin
			check("reserved byte", rb[i], 8'h00);
		end
	endtask

	// Burst write to read-only places, then read from the stepped pointer.
	task automatic t_write();
		point(8'h01);
		put(8'h55, 1'b0, "data byte ack");
		put(8'h66, 1'b0, "second data ack");
		acp_i2c_master_i.m_stop();
		fetch(1);
		check("pointer after write", rb[0], last.y[11:4]);
		point(8'h01);
		fetch(1);
		check("read-only kept", rb[0], last.x[11:4]);
	endtask

	// Fill the buffer while the reader stalls, then drain it set by set.
	task automatic t_full();
		for (int k = 2; k < 12; k++) begin
			sq.push_back(mkset(4'(k)));
		end
		repeat (300) @(posedge sample_clk);
		@(negedge sample_clk);
		check("ready while full", {7'h00, sample_ready}, 8'h00);
		point(8'h00);
		fetch(1);
		check("status full", rb[0], 8'h88);
		for (int k = 2; k < 12; k++) begin
			point(8'h00);
			fetch(7);
			check_set(mkset(4'(k)));
			repeat (50) @(posedge mclk);
		end
		point(8'h00);
		fetch(1);
		check("status drained", rb[0], 8'h00);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Verdict and run control.
	task automatic report_and_stop();
		$display("Checks run %0d, mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Watchdog: the tests need about 300 us.
	initial begin
		#600000;
		n_errors++;
		report_and_stop();
	end

	initial begin
		repeat (3) @(posedge sample_clk);
		@(posedge mclk);
		resetn <= 1'b1;
		repeat (5) @(posedge mclk);
		t_idle();
		t_burst();
		t_reserved();
		t_write();
		t_full();
		report_and_stop();
	end
endmodule
`default_nettype wire
